/* include/lrr_pkg.sv */
// Constants and types for the return-with-immediate and rotate-through-spill unit.
// Assumes a core that decodes instructions and owns the program counter stack.
package lrr_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W   = 15;
	localparam int ADDR_W = 7;
	localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST    = 15'h0000;
	localparam logic              SPILL_RST = 1'h0;
	localparam logic              DEST_ACC  = 1'h0;
	localparam logic              DEST_REG  = 1'h1;
	localparam logic              READY_RST = 1'h1;
	localparam logic              PULSE_RST = 1'h0;
	localparam logic [ADDR_W-1:0] REG_ADDR_RST = 7'h00;
	localparam logic [DATA_W-1:0] REG_DATA_RST = 8'h00;
	localparam int MSB = DATA_W - 1;

	typedef enum logic [1:0] {
		LRR_OP_NONE  = 2'h0,
		LRR_OP_RETI  = 2'h1,
		LRR_OP_ROTL  = 2'h2,
		LRR_OP_ROTR  = 2'h3
	} lrr_op_t;

	typedef enum logic [1:0] {
		LRR_ST_IDLE  = 2'b00,
		LRR_ST_FETCH = 2'b01
	} lrr_state_t;
endpackage

/* core/lrr_rotator.sv */
// Combinational nine-bit rotate through the spill bit.
// Assumes operand and spill come from flip-flops on the core clock.
`timescale 1ns/1ps
module lrr_rotator
	import lrr_pkg::*;
(
	input  wire logic              left_in,
	input  wire logic [DATA_W-1:0] operand_in,
	input  wire logic              spill_in,
	output logic      [DATA_W-1:0] result_out,
	output logic                   spill_out
);
	always_comb begin
		if (left_in) begin
			result_out = {operand_in[MSB-1:0], spill_in};  // see RULE_04 see RULE_07
			spill_out  = operand_in[MSB];                   // see RULE_07
		end else begin
			result_out = {spill_in, operand_in[MSB:1]};     // see RULE_05 see RULE_07
			spill_out  = operand_in[0];                     // see RULE_07
		end
	end
endmodule

/* core/lrr_core.sv */
// Execution unit for return-with-immediate and the two rotate-through-spill ops.
// Assumes the decoder presents one instruction per cycle while ready_out is high,
// and that operand_in holds the addressed register contents in that cycle.
// Ops offered while ready_out is low are dropped, not queued; the decoder must hold them.
//
// Contract
// RULE_01 - Return-with-immediate loads its 8-bit immediate into the accumulator.
// RULE_02 - Return-with-immediate pops the stack and loads PC from the stack head.
// RULE_03 - Return-with-immediate is one word, two cycles, leaves status flags alone.
// RULE_04 - Rotate left moves the operand one place left through the spill bit.
// RULE_05 - Rotate right moves the operand one place right through the spill bit.
// RULE_06 - Target bit 0 writes the accumulator, 1 writes back the operand register.
// RULE_07 - Left: bit 7 to spill, spill to bit 0; right mirrored; one cycle.
`timescale 1ns/1ps
module lrr_core
	import lrr_pkg::*;
(
	input  wire logic              ref_clk_in,
	input  wire logic              rst_b_in,
	input  wire lrr_op_t           op_in,
	input  wire logic [DATA_W-1:0] imm_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              dest_in,
	input  wire logic [DATA_W-1:0] operand_in,
	input  wire logic [PC_W-1:0]   stack_head_in,
	output logic      [DATA_W-1:0] acc_out,
	output logic                   spill_out,
	output logic      [PC_W-1:0]   pc_out,
	output logic                   pc_load_out,
	output logic                   stack_pop_out,
	output logic                   reg_we_out,
	output logic      [ADDR_W-1:0] reg_addr_out,
	output logic      [DATA_W-1:0] reg_data_out,
	output logic                   ready_out
);
	lrr_state_t        state;
	lrr_state_t        next_state;
	logic              go;
	logic              take_ret;
	logic              take_rot;
	logic              rot_left;
	logic              rot_to_acc;
	logic              rot_to_reg;
	logic [DATA_W-1:0] rot_val;
	logic              rot_spill;

	// Opcode decode feeds the take_ret and take_rot strobes; the sequencer and the spill and data registers case on op_in directly
	function automatic logic op_is_return(input lrr_op_t op);
		return op == LRR_OP_RETI;
	endfunction

	function automatic logic op_is_rotate(input lrr_op_t op);
		return (op == LRR_OP_ROTL) || (op == LRR_OP_ROTR);
	endfunction

	function automatic logic dest_is_acc(input logic dest);
		return dest == DEST_ACC;
	endfunction

	// Only the idle slot takes an op; whatever sits on op_in in the dead slot is dropped
	assign go         = (state == LRR_ST_IDLE);
	assign take_ret   = go && op_is_return(op_in);
	assign take_rot   = go && op_is_rotate(op_in);
	assign rot_left   = (op_in == LRR_OP_ROTL);
	assign rot_to_acc = take_rot && dest_is_acc(dest_in);
	assign rot_to_reg = take_rot && !dest_is_acc(dest_in);

	lrr_rotator lrr_rotator_inst (
		.left_in    (rot_left),
		.operand_in (operand_in),
		.spill_in   (spill_out),
		.result_out (rot_val),
		.spill_out  (rot_spill)
	);

	// Second cycle of the return is a dead slot while the fetch refills
	always_comb begin
		next_state = state;
		case (state)
			LRR_ST_IDLE: begin
				case (op_in)
					LRR_OP_RETI: begin
						next_state = LRR_ST_FETCH;  // see RULE_03
					end
					LRR_OP_ROTL: begin
						next_state = LRR_ST_IDLE;  // see RULE_07
					end
					LRR_OP_ROTR: begin
						next_state = LRR_ST_IDLE;  // see RULE_07
					end
					default: begin
						next_state = LRR_ST_IDLE;
					end
				endcase
			end
			LRR_ST_FETCH: begin
				next_state = LRR_ST_IDLE;
			end
			default: begin
				next_state = LRR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			state <= LRR_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Registered from next_state so the decoder sees the stall without a path through op_in
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			ready_out <= READY_RST;
		end else begin
			case (next_state)
				LRR_ST_IDLE: begin
					ready_out <= 1'h1;
				end
				default: begin
					ready_out <= 1'h0;  // see RULE_03
				end
			endcase
		end
	end

	// Return and rotate never share a slot, so the accumulator has one writer per cycle
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			acc_out <= ACC_RST;
		end else if (go) begin
			case (op_in)
				LRR_OP_RETI: begin
					acc_out <= imm_in;  // see RULE_01
				end
				LRR_OP_ROTL, LRR_OP_ROTR: begin
					if (rot_to_acc) begin
						acc_out <= rot_val;  // see RULE_06
					end
				end
				default: begin
					acc_out <= acc_out;
				end
			endcase
		end
	end

	// Return leaves spill untouched; only rotates change it
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			spill_out <= SPILL_RST;
		end else if (go) begin
			case (op_in)
				LRR_OP_ROTL, LRR_OP_ROTR: begin
					spill_out <= rot_spill;  // see RULE_04 see RULE_05
				end
				LRR_OP_RETI: begin
					spill_out <= spill_out;  // see RULE_03
				end
				default: begin
					spill_out <= spill_out;
				end
			endcase
		end
	end

	// Popping and loading share one decode so the stack and the PC cannot disagree
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			pc_out <= PC_RST;
		end else if (take_ret) begin
			pc_out <= stack_head_in;  // see RULE_02
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			pc_load_out <= PULSE_RST;
		end else begin
			pc_load_out <= take_ret;  // see RULE_02
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			stack_pop_out <= PULSE_RST;
		end else begin
			stack_pop_out <= take_ret;  // see RULE_02
		end
	end

	// Write-back strobe only when the target bit picks the register file
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			reg_we_out <= PULSE_RST;
		end else begin
			reg_we_out <= rot_to_reg;  // see RULE_06
		end
	end

	// Address and data load on every rotate, either target, then hold; the register file only looks while the strobe is high
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			reg_addr_out <= REG_ADDR_RST;
		end else if (take_rot) begin
			reg_addr_out <= addr_in;  // see RULE_06
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			reg_data_out <= REG_DATA_RST;
		end else if (go) begin
			case (op_in)
				LRR_OP_ROTL, LRR_OP_ROTR: begin
					reg_data_out <= rot_val;  // see RULE_06
				end
				default: begin
					reg_data_out <= reg_data_out;
				end
			endcase
		end
	end
endmodule

/* tb/lrr_checker.sv */
// Checker for lrr_core port behaviour
// Bound into every lrr_core instance; sees ports only
`timescale 1ns/1ps
module lrr_checker
	import lrr_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        rst_b_in,
	input wire lrr_op_t     op_in,
	input wire logic [7:0]  imm_in,
	input wire logic        dest_in,
	input wire logic [7:0]  operand_in,
	input wire logic [14:0] stack_head_in,
	input wire logic [7:0]  acc_out,
	input wire logic        spill_out,
	input wire logic [14:0] pc_out,
	input wire logic        stack_pop_out,
	input wire logic        reg_we_out,
	input wire logic [7:0]  reg_data_out,
	input wire logic        ready_out
);
	logic            pd;
	wire logic [7:0] res = pd ? reg_data_out : acc_out;
	always_ff @(posedge ref_clk_in) pd <= dest_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_ret; ready_out && op_in == LRR_OP_RETI; endsequence
	sequence s_rot; ready_out && op_in[1]; endsequence
	AST_RET_ACC: assert property (s_ret |=> acc_out == $past(imm_in))
		else $error("acc not loaded");
	AST_RET_PC: assert property (s_ret |=> pc_out == $past(stack_head_in) && stack_pop_out)
		else $error("pc not loaded");
	AST_RET_TWO: assert property (s_ret |=> !ready_out && $stable(spill_out) ##1 ready_out)
		else $error("return timing");
	AST_ROTL: assert property (s_rot ##0 !op_in[0] |=>
		{spill_out, res} == {$past(operand_in), $past(spill_out)}) else $error("left rotate");
	AST_ROTR: assert property (s_rot ##0 op_in[0] |=>
		{res, spill_out} == {$past(spill_out), $past(operand_in)}) else $error("right rotate");
	AST_DEST: assert property (s_rot |=> reg_we_out == $past(dest_in))
		else $error("target");
	AST_ONE: assert property (s_rot |=> ready_out)
		else $error("rotate stalls");
	AST_POP_PULSE: assert property (stack_pop_out |=> !stack_pop_out)
		else $error("pop pulse too long");
	AST_DEAD_SLOT: assert property (s_ret ##1 op_in[1] |=> !reg_we_out && $stable(acc_out) && $stable(spill_out))
		else $error("op taken in dead slot");
endmodule
bind lrr_core lrr_checker lrr_checker_inst (.*);

/* tb/literal_return_and_rotate_tb.sv */
// Bench for lrr_core: return and rotate cases
// Drives the ports itself; checker is bound from its own file
`timescale 1ns/1ps
module literal_return_and_rotate_tb;
	import lrr_pkg::*;
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
	logic ref_clk_in = 1'h0, rst_b_in = 1'h0, dest_in = 1'h0;
	lrr_op_t op_in = LRR_OP_NONE;
	logic [7:0] imm_in = 8'h00, operand_in = 8'h00, acc_out, reg_data_out;
	logic [6:0] addr_in = 7'h00, reg_addr_out;
	logic [14:0] stack_head_in = 15'h0000, pc_out;
	logic spill_out, pc_load_out, stack_pop_out, reg_we_out, ready_out;
	int num_errors = 0, n_compared = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	lrr_core lrr_core_inst (
		.ref_clk_in    (ref_clk_in),
		.rst_b_in      (rst_b_in),
		.op_in         (op_in),
		.imm_in        (imm_in),
		.addr_in       (addr_in),
		.dest_in       (dest_in),
		.operand_in    (operand_in),
		.stack_head_in (stack_head_in),
		.acc_out       (acc_out),
		.spill_out     (spill_out),
		.pc_out        (pc_out),
		.pc_load_out   (pc_load_out),
		.stack_pop_out (stack_pop_out),
		.reg_we_out    (reg_we_out),
		.reg_addr_out  (reg_addr_out),
		.reg_data_out  (reg_data_out),
		.ready_out     (ready_out)
	);
	task automatic go(lrr_op_t o, logic [7:0] v, logic d);
		@(posedge ref_clk_in);
		op_in <= o;
		imm_in <= v;
		operand_in <= v;
		dest_in <= d;
		addr_in <= v[6:0];
		stack_head_in <= {v[6:0], v};
		@(posedge ref_clk_in);
		op_in <= LRR_OP_NONE;
		#1;
	endtask
	task automatic rot(logic l, logic d, logic [7:0] v);
		logic s;
		s = spill_out;
		go(l ? LRR_OP_ROTL : LRR_OP_ROTR, v, d);
		`CHK("spill", l ? v[7] : v[0], spill_out)
		`CHK("result", l ? {v[6:0], s} : {s, v[7:1]}, d ? reg_data_out : acc_out)
		`CHK("write", d, reg_we_out)
		`CHK("addr", v[6:0], reg_addr_out)
	endtask
	task automatic rot_pair(logic [7:0] a, logic [7:0] b);
		logic s;
		s = spill_out;
		@(posedge ref_clk_in);
		op_in <= LRR_OP_ROTL;
		operand_in <= a;
		dest_in <= 1'h1;
		addr_in <= 7'h15;
		@(posedge ref_clk_in);
		op_in <= LRR_OP_ROTR;
		operand_in <= b;
		dest_in <= 1'h0;
		#1;
		`CHK("pair first", {a[7], a[6:0], s, 1'h1}, {spill_out, reg_data_out, reg_we_out})
		@(posedge ref_clk_in);
		op_in <= LRR_OP_NONE;
		#1;
		`CHK("pair second", {a[7], b[7:1], b[0], 1'h0}, {acc_out, spill_out, reg_we_out})
	endtask
	task automatic ret_drop(logic [7:0] v);
		logic s;
		s = spill_out;
		@(posedge ref_clk_in);
		op_in <= LRR_OP_RETI;
		imm_in <= v;
		stack_head_in <= {v[6:0], v};
		@(posedge ref_clk_in);
		op_in <= LRR_OP_ROTL;
		operand_in <= ~v;
		dest_in <= 1'h0;
		@(posedge ref_clk_in);
		op_in <= LRR_OP_NONE;
		#1;
		`CHK("dead slot", {v, s, 4'h8}, {acc_out, spill_out, ready_out, pc_load_out, stack_pop_out, reg_we_out})
	endtask
	task automatic ret(logic [7:0] v);
		logic s;
		s = spill_out;
		go(LRR_OP_RETI, v, 1'h1);
		`CHK("acc", v, acc_out)
		`CHK("pc", {v[6:0], v, 2'h3}, {pc_out, pc_load_out, stack_pop_out})
		`CHK("busy", {s, 1'h0}, {spill_out, ready_out})
	endtask
	task automatic complete_run();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk_in);
		rst_b_in <= 1'h1;
		rot(1'h1, 1'h0, 8'he6);
		rot(1'h0, 1'h1, 8'h81);
		ret(8'hff);
		rot(1'h1, 1'h1, 8'h7f);
		ret(8'h00);
		rot(1'h0, 1'h0, 8'h00);
		rot_pair(8'h96, 8'h3c);
		ret_drop(8'h5a);
		complete_run();
	end
	initial begin
		#20000;
		num_errors++;
		complete_run();
	end
endmodule
